// *** tb/tb.sv ***
// Self-checking bench for the indexed literal offset executor
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ext_in = 1'b1;
    logic instr_valid = 1'b0;
    logic w_load = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [3:0] bank_sel = 4'h0;
    logic [11:0] ptr = 12'h000;
    logic [7:0] w_load_data = 8'h00;
    logic [7:0] rdata = 8'h00;
    ilo_pkg::ilo_phase_type phase;
    ilo_pkg::ilo_flags_type flags;
    logic ext_enabled, data_rd, data_wr, done;
    logic [11:0] data_addr;
    logic [7:0] wdata, w_reg;
    logic [7:0] mem [0:4095];
    logic [31:0] lfsr = 32'h76966b1c;
    logic [31:0] r, r2;
    logic [7:0] w_exp = 8'h00;
    logic [4:0] f_exp = 5'h00;
    logic [7:0] corner [0:3] = '{8'h00, 8'h5f, 8'h60, 8'hff};
    logic [15:0] op;
    int n_fail = 0;
    int cmp_count = 0;

    ilo_exec dut (.CLK(clk), .RST(rst), .EXTENDED_SET_ENABLE(ext_in), .INSTR(instr),
        .INSTR_VALID(instr_valid), .BANK_SELECT_REGISTER(bank_sel), .INDIRECT_POINTER_TWO(ptr),
        .W_LOAD(w_load), .W_LOAD_DATA(w_load_data), .DATA_RDATA(rdata), .PHASE(phase),
        .EXT_ENABLED(ext_enabled), .DATA_ADDR(data_addr), .DATA_RD(data_rd),
        .DATA_WR(data_wr), .DATA_WDATA(wdata), .W_REG(w_reg), .FLAGS(flags), .DONE(done));

    always #5 clk = ~clk;

    // ========================================================================
    // Data memory: registered read, stale data toggles when not read
    // ========================================================================
    always @(posedge clk)
    begin
        rdata <= data_rd ? mem[data_addr] : ~rdata;
        if (data_wr)
        begin
            mem[data_addr] <= wdata;
        end
    end

    // ========================================================================
    // Helpers
    // ========================================================================
    function automatic logic [31:0] get_rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            n_fail++;
        end
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    function automatic logic [11:0] exp_addr(input logic e, input logic [15:0] i,
                                             input logic [3:0] b, input logic [11:0] p);
        if (i[8])
            return {b, i[7:0]};
        if (e && i[7:0] <= 8'h5f)
            return p + {4'h0, i[7:0]};
        if (i[7:0] > 8'h5f)
            return {4'hf, i[7:0]};
        return {4'h0, i[7:0]};
    endfunction

    // One instruction cycle, W preloaded in the Q4 before issue
    task automatic exec(input logic [15:0] i, input logic e, input logic [3:0] b,
                        input logic [11:0] p, input logic [7:0] wv);
        logic [11:0] a;
        logic [7:0] m, wd;
        logic [8:0] s;
        logic [4:0] h;
        logic is_add, is_bitset;
        is_add = (i[15:10] == 6'b001001);
        is_bitset = (i[15:12] == 4'h8);
        a = exp_addr(e, i, b, p);
        do @(negedge clk); while (phase !== ilo_pkg::ILO_Q3);
        @(posedge clk);
        w_load <= 1'b1;
        w_load_data <= wv;
        ext_in <= e;
        bank_sel <= b;
        ptr <= p;
        instr <= i;
        @(posedge clk);
        w_load <= 1'b0;
        instr_valid <= 1'b1;
        w_exp = wv;
        m = mem[a];
        s = {1'b0, wv} + {1'b0, m};
        h = {1'b0, wv[3:0]} + {1'b0, m[3:0]};
        @(posedge clk);
        instr_valid <= 1'b0;
        @(negedge clk);
        check("ext_enabled", ext_enabled, e);
        check("data_rd", data_rd, is_add | is_bitset);
        check("data_addr", data_addr, a);
        repeat (2) @(negedge clk);
        wd = is_add ? s[7:0] : (is_bitset ? (m | (8'h01 << i[11:9])) : 8'hff);
        check("data_wr", data_wr, !(is_add && !i[9]));
        if (data_wr === 1'b1)
            check("data_wdata", wdata, wd);
        @(negedge clk);
        check("done", done, 1'b1);
        if (is_add)
        begin
            f_exp = {s[7], (wv[7] == m[7]) && (s[7] != wv[7]), s[7:0] == 8'h00, h[4], s[8]};
            if (!i[9])
                w_exp = s[7:0];
        end
        check("w_reg", w_reg, w_exp);
        check("flags", flags, f_exp);
    endtask

    // Issue that must leave no trace: wrong phase or unknown opcode
    task automatic quiet(input logic [15:0] i, input ilo_pkg::ilo_phase_type ph);
        do @(negedge clk); while (phase !== ph);
        @(posedge clk);
        instr <= i;
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        repeat (8)
        begin
            @(negedge clk);
            check("quiet_wr", data_wr, 1'b0);
            check("quiet_done", done, 1'b0);
        end
        check("quiet_w", w_reg, w_exp);
    endtask

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial
    begin
        for (int k = 0; k < 4096; k++)
        begin
            r = get_rnd();
            mem[k] = r[7:0];
        end
        repeat (20) @(posedge clk);
        @(negedge clk);
        check("rst_phase", phase, ilo_pkg::ILO_Q1);
        check("rst_ext", ext_enabled, 1'b0);
        check("rst_w", w_reg, 8'h00);
        check("rst_flags", flags, 5'h00);
        @(posedge clk);
        rst <= 1'b0;
        mem[12'ha2c] = 8'h20;
        mem[12'ha0a] = 8'h55;
        exec(16'h242c, 1'b1, 4'h0, 12'ha00, 8'h17);
        exec(16'h8e0a, 1'b1, 4'h0, 12'ha00, 8'h00);
        exec(16'h682c, 1'b1, 4'h0, 12'ha00, 8'h00);
        exec(16'h265f, 1'b1, 4'h3, 12'hfff, 8'hff);
        exec(16'h2660, 1'b1, 4'h3, 12'h100, 8'h80);
        exec(16'h2510, 1'b1, 4'h7, 12'h100, 8'h01);
        exec(16'h2410, 1'b0, 4'h7, 12'h100, 8'h7f);
        for (int n = 0; n < 150; n++)
        begin
            r = get_rnd();
            r2 = get_rnd();
            case (r[1:0] % 3)
                0: op = {6'b001001, r[2], r[3] & r[7], 8'h00};
                1: op = {4'h8, r[6:4], r[3] & r[7], 8'h00};
                default: op = {7'b0110100, r[3] & r[7], 8'h00};
            endcase
            op[7:0] = (r[9:8] == 2'b00) ? corner[r[11:10]] : r[19:12];
            exec(op, r[21] | r[22], r[27:24], r[20] ? 12'h000 : r[31:20], r2[7:0]);
        end
        quiet(16'h682c, ilo_pkg::ILO_Q1);
        quiet(16'hffff, ilo_pkg::ILO_Q4);
        tally_and_finish();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire

// *** verilog/ilo_exec.sv ***
// Indexed literal offset decode and execute for add, bit set and set all
//
// Operation
// - Extended on, operand up to 5Fh: address is pointer two plus operand.
// - Indexing only when access bit is zero; else bank select register bank.
// - Pointer two at zero reproduces the original access bank addresses.
// - Indexed add sums working register with byte at pointer plus k.
// - Destination bit 0 writes working register, 1 writes the memory byte.
// - Indexed add updates negative, overflow, carry, digit carry, zero flags.
// - Add recognised by upper byte 0010 01d0, low byte is offset.
// - Bit set 1000 bbb0 sets bit b at pointer plus offset, flags kept.
// - Set all 0110 1000 writes FFh at pointer plus offset, flags kept.
// - Extended enable configuration bit defaults to 0, disabling the mode.
`timescale 1ns/100ps
`default_nettype none

module ilo_exec
#(
    parameter int ADDR_W = ilo_pkg::ILO_ADDR_W
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic EXTENDED_SET_ENABLE,
    input wire logic [15:0] INSTR,
    input wire logic INSTR_VALID,
    input wire logic [3:0] BANK_SELECT_REGISTER,
    input wire logic [ADDR_W-1:0] INDIRECT_POINTER_TWO,
    input wire logic W_LOAD,
    input wire logic [7:0] W_LOAD_DATA,
    input wire logic [7:0] DATA_RDATA,
    output ilo_pkg::ilo_phase_type PHASE,
    output logic EXT_ENABLED,
    output logic [ADDR_W-1:0] DATA_ADDR,
    output logic DATA_RD,
    output logic DATA_WR,
    output logic [7:0] DATA_WDATA,
    output logic [7:0] W_REG,
    output ilo_pkg::ilo_flags_type FLAGS,
    output logic DONE
);

    // ========================================================================
    // Decode
    // ========================================================================
    ilo_pkg::ilo_op_type dec_op;
    logic [ADDR_W-1:0] dec_addr;
    logic [7:0] f_field;

    assign f_field = INSTR[7:0];

    always_comb
    begin
        if (INSTR[15:10] == ilo_pkg::ILO_ADD_PAT)
            dec_op = ilo_pkg::ILO_OP_ADD;
        else if (INSTR[15:12] == ilo_pkg::ILO_BITSET_PAT)
            dec_op = ilo_pkg::ILO_OP_BITSET;
        else if (INSTR[15:9] == ilo_pkg::ILO_SETALL_PAT)
            dec_op = ilo_pkg::ILO_OP_SETALL;
        else
            dec_op = ilo_pkg::ILO_OP_NONE;
    end

    always_comb
    begin
        if (INSTR[ilo_pkg::ILO_A_POS])
            dec_addr = ADDR_W'({BANK_SELECT_REGISTER, f_field});
        else if (f_field > ilo_pkg::ILO_ACCESS_LIMIT)
            dec_addr = ADDR_W'({ilo_pkg::ILO_SFR_BANK, f_field});
        else if (EXTENDED_SET_ENABLE)
            dec_addr = INDIRECT_POINTER_TWO + ADDR_W'(f_field);
        else
            dec_addr = ADDR_W'(f_field);
    end

    // ========================================================================
    // Phase sequencer
    // ========================================================================
    ilo_pkg::ilo_phase_type phase;
    ilo_pkg::ilo_phase_type next_phase;

    always_comb
    begin
        case (phase)
            ilo_pkg::ILO_Q1: next_phase = ilo_pkg::ILO_Q2;
            ilo_pkg::ILO_Q2: next_phase = ilo_pkg::ILO_Q3;
            ilo_pkg::ILO_Q3: next_phase = ilo_pkg::ILO_Q4;
            ilo_pkg::ILO_Q4: next_phase = ilo_pkg::ILO_Q1;
            default: next_phase = ilo_pkg::ILO_Q1;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            phase <= ilo_pkg::ILO_Q1;
        else
            phase <= next_phase;
    end

    // ========================================================================
    // Execute
    // ========================================================================
    logic ext;
    ilo_pkg::ilo_op_type op;
    logic dest_file;
    logic [2:0] bit_sel;
    logic [ADDR_W-1:0] addr;
    logic data_rd;
    logic data_wr;
    logic [7:0] data_wdata;
    logic [7:0] w;
    ilo_pkg::ilo_flags_type flags;
    ilo_pkg::ilo_flags_type pend_flags;
    logic done;
    logic next_ext;
    ilo_pkg::ilo_op_type next_op;
    logic next_dest_file;
    logic [2:0] next_bit_sel;
    logic [ADDR_W-1:0] next_addr;
    logic next_data_rd;
    logic next_data_wr;
    logic [7:0] next_data_wdata;
    logic [7:0] next_w;
    ilo_pkg::ilo_flags_type next_flags;
    ilo_pkg::ilo_flags_type next_pend_flags;
    logic next_done;
    logic [8:0] add_sum;
    logic [4:0] low_sum;

    assign add_sum = {1'b0, w} + {1'b0, DATA_RDATA};
    assign low_sum = {1'b0, w[3:0]} + {1'b0, DATA_RDATA[3:0]};

    always_comb
    begin
        next_ext = ext;
        next_op = op;
        next_dest_file = dest_file;
        next_bit_sel = bit_sel;
        next_addr = addr;
        next_data_rd = 1'b0;
        next_data_wr = 1'b0;
        next_data_wdata = data_wdata;
        next_w = W_LOAD ? W_LOAD_DATA : w;
        next_flags = flags;
        next_pend_flags = pend_flags;
        next_done = 1'b0;
        case (phase)
            ilo_pkg::ILO_Q1:
            begin
                next_ext = EXTENDED_SET_ENABLE;
                next_op = INSTR_VALID ? dec_op : ilo_pkg::ILO_OP_NONE;
                next_dest_file = INSTR[ilo_pkg::ILO_D_POS];
                next_bit_sel = INSTR[ilo_pkg::ILO_BIT_LSB +: 3];
                next_addr = dec_addr;
                next_data_rd = INSTR_VALID && (dec_op == ilo_pkg::ILO_OP_ADD
                    || dec_op == ilo_pkg::ILO_OP_BITSET);
            end
            ilo_pkg::ILO_Q2: next_op = op;
            ilo_pkg::ILO_Q3:
            begin
                case (op)
                    ilo_pkg::ILO_OP_ADD:
                    begin
                        next_data_wdata = add_sum[7:0];
                        next_data_wr = dest_file;
                        next_pend_flags.c = add_sum[8];
                        next_pend_flags.digit_carry_flag = low_sum[4];
                        next_pend_flags.z = (add_sum[7:0] == ilo_pkg::ILO_BYTE_RESET);
                        next_pend_flags.n = add_sum[7];
                        next_pend_flags.overflow_flag = (w[7] == DATA_RDATA[7])
                            && (add_sum[7] != w[7]);
                    end
                    ilo_pkg::ILO_OP_BITSET:
                    begin
                        next_data_wdata = DATA_RDATA | (ilo_pkg::ILO_BIT_ONE << bit_sel);
                        next_data_wr = 1'b1;
                    end
                    ilo_pkg::ILO_OP_SETALL:
                    begin
                        next_data_wdata = ilo_pkg::ILO_ALL_ONES;
                        next_data_wr = 1'b1;
                    end
                    default: next_data_wr = 1'b0;
                endcase
            end
            ilo_pkg::ILO_Q4:
            begin
                if (op == ilo_pkg::ILO_OP_ADD)
                begin
                    next_flags = pend_flags;
                    if (!dest_file)
                        next_w = data_wdata;
                end
                next_done = (op != ilo_pkg::ILO_OP_NONE);
                next_op = ilo_pkg::ILO_OP_NONE;
            end
            default: next_op = ilo_pkg::ILO_OP_NONE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ext <= ilo_pkg::ILO_EXT_RESET;
            op <= ilo_pkg::ILO_OP_NONE;
            dest_file <= 1'b0;
            bit_sel <= 3'h0;
            addr <= '0;
            data_rd <= 1'b0;
            data_wr <= 1'b0;
            data_wdata <= ilo_pkg::ILO_BYTE_RESET;
            w <= ilo_pkg::ILO_W_RESET;
            flags <= ilo_pkg::ILO_FLAGS_RESET;
            pend_flags <= ilo_pkg::ILO_FLAGS_RESET;
            done <= 1'b0;
        end
        else
        begin
            ext <= next_ext;
            op <= next_op;
            dest_file <= next_dest_file;
            bit_sel <= next_bit_sel;
            addr <= next_addr;
            data_rd <= next_data_rd;
            data_wr <= next_data_wr;
            data_wdata <= next_data_wdata;
            w <= next_w;
            flags <= next_flags;
            pend_flags <= next_pend_flags;
            done <= next_done;
        end
    end

    assign PHASE = phase;
    assign EXT_ENABLED = ext;
    assign DATA_ADDR = addr;
    assign DATA_RD = data_rd;
    assign DATA_WR = data_wr;
    assign DATA_WDATA = data_wdata;
    assign W_REG = w;
    assign FLAGS = flags;
    assign DONE = done;

    // ========================================================================
    // Checks
    // ========================================================================
    logic q1_take;
    assign q1_take = (phase == ilo_pkg::ILO_Q1) && INSTR_VALID;

    default clocking ck @(posedge CLK); endclocking
    default disable iff (RST);

    index_addr_a: assert property (q1_take && EXTENDED_SET_ENABLE && !INSTR[8]
        && (INSTR[7:0] <= ilo_pkg::ILO_ACCESS_LIMIT)
        |=> DATA_ADDR == ADDR_W'($past(INDIRECT_POINTER_TWO) + ADDR_W'($past(INSTR[7:0]))))
        else $error("indexed address wrong");
    bank_addr_a: assert property (q1_take && INSTR[8]
        |=> DATA_ADDR == ADDR_W'({$past(BANK_SELECT_REGISTER), $past(INSTR[7:0])}))
        else $error("banked address wrong");
    legacy_zero_a: assert property (q1_take && (INDIRECT_POINTER_TWO == '0) && !INSTR[8]
        && (INSTR[7:0] <= ilo_pkg::ILO_ACCESS_LIMIT)
        |=> DATA_ADDR == ADDR_W'($past(INSTR[7:0])))
        else $error("zero pointer address differs from access bank");
    add_file_a: assert property (phase == ilo_pkg::ILO_Q3 && op == ilo_pkg::ILO_OP_ADD
        && dest_file |=> DATA_WR && DATA_WDATA == 8'($past(W_REG) + $past(DATA_RDATA)))
        else $error("add to file wrong");
    add_w_a: assert property (phase == ilo_pkg::ILO_Q3 && op == ilo_pkg::ILO_OP_ADD
        && !dest_file |=> !DATA_WR ##1 W_REG == 8'($past(W_REG, 2) + $past(DATA_RDATA, 2)))
        else $error("add to working register wrong");
    add_flags_a: assert property (phase == ilo_pkg::ILO_Q3 && op == ilo_pkg::ILO_OP_ADD
        |-> ##2 {FLAGS.c, FLAGS.n}
        == 2'(({1'b0, $past(W_REG, 2)} + {1'b0, $past(DATA_RDATA, 2)}) >> 7)
        && FLAGS.z == (8'($past(W_REG, 2) + $past(DATA_RDATA, 2)) == 8'h00))
        else $error("add flags wrong");
    bit_set_a: assert property (phase == ilo_pkg::ILO_Q3 && op == ilo_pkg::ILO_OP_BITSET
        |=> DATA_WR && DATA_WDATA == ($past(DATA_RDATA) | (8'h01 << $past(bit_sel)))
        ##1 $stable(FLAGS))
        else $error("bit set wrong");
    set_all_a: assert property (phase == ilo_pkg::ILO_Q3 && op == ilo_pkg::ILO_OP_SETALL
        |=> DATA_WR && DATA_WDATA == 8'hff ##1 $stable(FLAGS))
        else $error("set all wrong");
    ext_reset_a: assert property (@(posedge CLK) disable iff (1'b0) RST |=> !EXT_ENABLED)
        else $error("extended enable not cleared by reset");
    one_cycle_a: assert property (q1_take && dec_op != ilo_pkg::ILO_OP_NONE
        |-> ##4 DONE && PHASE == ilo_pkg::ILO_Q1)
        else $error("instruction not finished in one cycle");
    add_decode_a: assert property (q1_take && INSTR[15:10] == 6'h09
        |=> op == ilo_pkg::ILO_OP_ADD && DATA_RD)
        else $error("add not decoded");

endmodule // ilo_exec

`default_nettype wire

// *** verilog/ilo_pkg.sv ***
// Constants and types for the indexed literal offset executor
`default_nettype none

package ilo_pkg;

    // ========================================================================
    // Widths and address map
    // ========================================================================
    localparam int ILO_ADDR_W = 12;
    localparam logic [7:0] ILO_ACCESS_LIMIT = 8'h5f;
    localparam logic [3:0] ILO_SFR_BANK = 4'hf;

    // ========================================================================
    // Opcode fields and patterns
    // ========================================================================
    localparam int ILO_A_POS = 8;
    localparam int ILO_D_POS = 9;
    localparam int ILO_BIT_LSB = 9;
    localparam logic [5:0] ILO_ADD_PAT = 6'h09;
    localparam logic [3:0] ILO_BITSET_PAT = 4'h8;
    localparam logic [6:0] ILO_SETALL_PAT = 7'h34;
    localparam logic [7:0] ILO_ALL_ONES = 8'hff;
    localparam logic [7:0] ILO_BIT_ONE = 8'h01;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic ILO_EXT_RESET = 1'b0;
    localparam logic [7:0] ILO_W_RESET = 8'h00;
    localparam logic [7:0] ILO_BYTE_RESET = 8'h00;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [1:0] {
        ILO_Q1 = 2'b00,
        ILO_Q2 = 2'b01,
        ILO_Q3 = 2'b10,
        ILO_Q4 = 2'b11
    } ilo_phase_type;

    typedef enum logic [1:0] {
        ILO_OP_NONE = 2'b00,
        ILO_OP_ADD = 2'b01,
        ILO_OP_BITSET = 2'b10,
        ILO_OP_SETALL = 2'b11
    } ilo_op_type;

    typedef struct packed {
        logic n;
        logic overflow_flag;
        logic z;
        logic digit_carry_flag;
        logic c;
    } ilo_flags_type;

    localparam ilo_flags_type ILO_FLAGS_RESET = 5'h00;

endpackage

`default_nettype wire
